// ==== verilog/sdi_pkg.sv ====
// Purpose: constants for the startup diagnostic indicator
// Assumes: 32-bit ahb-lite register access, 250 MHz hclk
// Notes:   segment bit order is {dp,g,f,e,d,c,b,a}
package sdi_pkg;
  // clock
  localparam int unsigned CLK_MHZ        = 250;
  // timing figures in their own units
  localparam int unsigned LAMP_HALF_MS   = 500;   // processor lamp half period
  localparam int unsigned INIT_LIMIT_S   = 30;    // d phase ends by then
  localparam int unsigned DIAG_LIMIT_S   = 60;    // one minute watchdog
  localparam longint LAMP_HALF_CYC = longint'(LAMP_HALF_MS) * CLK_MHZ * 1000;
  localparam longint INIT_LIMIT_CYC = longint'(INIT_LIMIT_S) * CLK_MHZ
                                      * 1000000;
  localparam longint DIAG_LIMIT_CYC = longint'(DIAG_LIMIT_S) * CLK_MHZ
                                      * 1000000;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00; // done/fault/init_done/svc
  localparam logic [7:0] OFS_DIV    = 8'h04; // step divider
  localparam logic [7:0] OFS_ALARM  = 8'h08; // major count, all acked
  localparam logic [7:0] OFS_HEALTH = 8'h0c; // board and supply health
  localparam logic [7:0] OFS_STAT   = 8'h10; // sticky events, read clears
  localparam logic [7:0] OFS_MASK   = 8'h14; // interrupt mask
  localparam logic [7:0] OFS_DISP   = 8'h18; // phase and segment readback
  // ctrl fields
  localparam int CTRL_DONE  = 0;   // diagnostics finished
  localparam int CTRL_FAULT = 1;   // self-test failed, code in [7:4]
  localparam int CTRL_INIT  = 2;   // software and database ready
  localparam int CTRL_SVC   = 3;   // service fault, glyph in [9:8]
  localparam int CODE_LSB   = 4;
  localparam int SVC_LSB    = 8;
  // event bits
  localparam int EV_FAULT   = 0;
  localparam int EV_DONE    = 1;
  localparam int EV_READY   = 2;
  localparam int EV_TIMEOUT = 3;
  localparam int EV_W       = 4;
  localparam logic [31:0] DIV_RST = 32'h017d7840; // 0.1 s step at reset
  // glyphs {dp,g,f,e,d,c,b,a} without dot
  localparam logic [6:0] GL_P = 7'h73;
  localparam logic [6:0] GL_D = 7'h5e;
  localparam logic [6:0] GL_F = 7'h71;
  localparam logic [6:0] GL_C = 7'h39;
  localparam logic [6:0] GL_L = 7'h38;
  localparam logic [6:0] GL_U = 7'h3e;
  localparam logic [6:0] GL_BLANK = 7'h00;
  // fault codes
  localparam logic [3:0] FC_BOOT_IMAGE = 4'h1;
  localparam logic [3:0] FC_RAM        = 4'h2;
  localparam logic [3:0] FC_CPU        = 4'h3;
  localparam logic [3:0] FC_EXCH       = 4'h4;
  localparam logic [3:0] FC_TIMER      = 4'h5;
  localparam logic [3:0] FC_EXCH_EXT   = 4'hf;
  localparam int CHASE_STEPS = 12; // six segments each way
  typedef enum logic [2:0] {
    SDI_CHASE = 3'b000,
    SDI_PGLY  = 3'b001,
    SDI_DGLY  = 3'b010,
    SDI_COUNT = 3'b011,
    SDI_FAULT = 3'b100,
    SDI_SVC   = 3'b101
  } sdi_phase_t;
  // numeral to segments
  function automatic logic [6:0] sdi_digit(input logic [3:0] n);
    logic [6:0] s;
    s = GL_BLANK;
    case (n)
      4'h0: s = 7'h3f;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5b;
      4'h3: s = 7'h4f;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6d;
      4'h6: s = 7'h7d;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7f;
      4'h9: s = 7'h6f;
      4'hf: s = GL_F;
      default: s = GL_BLANK;
    endcase
    return s;
  endfunction : sdi_digit
endpackage : sdi_pkg

// ==== verilog/sdi_tick.sv ====
// Purpose: programmable divider giving a one-cycle tick
// Assumes: div of zero is treated as one
// Notes:   a smaller divider cuts the running count short at once
`timescale 1ns/10ps
module sdi_tick #(
  parameter int W = 32
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] div,
  output logic              tick
);
  logic [W-1:0] cnt_reg;  // down counter

  // count down and pulse on wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else if ((cnt_reg == '0) || (cnt_reg >= div)) begin
      // a count above a new, smaller divider would stall for the old period
      cnt_reg <= (div == '0) ? '0 : div - 1'b1;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
      tick    <= 1'b0;
    end
  end
endmodule : sdi_tick

// ==== verilog/sdi_indicator.sv ====
// Purpose: startup diagnostic indicator, display and lamp sequencer
// Assumes: single hclk, async active-low reset, ahb-lite single words
// Notes:   register access answers with zero wait states
//
// What this block does
// - chase segments clockwise then counter-clockwise
// - decimal dot always lit under power
// - flash P once when diagnostics finish
// - flash D while initializing, 30 s limit
// - flash major alarm count once ready
// - processor lamp blinks 0.5 s when acked
// - show fault code 1-5 or F
// - flag diagnostics running past one minute
// - control board lamp on when healthy
// - line board lamp on when healthy
// - one green lamp per working supply
// - glyphs C, L, U mark service faults
`timescale 1ns/10ps
module sdi_indicator
  import sdi_pkg::*;
#(
  parameter longint LAMP_HALF = LAMP_HALF_CYC,
  parameter longint INIT_MAX  = INIT_LIMIT_CYC,
  parameter longint DIAG_MAX  = DIAG_LIMIT_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [7:0]       seg_out,
  output logic             proc_lamp,
  output logic             ctrl_lamp,
  output logic             line_lamp,
  output logic [1:0]       supply_lamp,
  output logic             irq
);
  //////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0]     ctrl_reg;     // software controls and codes
  logic [31:0]     div_reg;      // step divider
  logic [3:0]      alarm_reg;    // major alarm count
  logic            acked_reg;    // all alarms acknowledged
  logic [3:0]      health_reg;   // ctrl, line, supply1, supply2
  logic [EV_W-1:0] stat_reg;     // sticky events
  logic [EV_W-1:0] mask_reg;     // interrupt enables
  sdi_phase_t      phase_reg;    // display phase
  logic [3:0]      chase_reg;    // chase position
  logic            flash_reg;    // glyph flash half
  logic [1:0]      pflash_reg;   // P flash progress
  logic [39:0]     tmr_reg;      // phase timer
  logic [31:0]     lamp_cnt_reg; // processor lamp half-period count
  logic            ph_reg;       // address phase captured
  logic            ph_wr_reg;    // captured write
  logic [7:0]      ph_addr_reg;  // captured offset
  logic            tick;         // divider tick
  logic [EV_W-1:0] ev;           // events this cycle
  logic            rd_stat;      // status read in data phase

  sdi_tick #(.W(32)) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .div     (div_reg),
    .tick    (tick)
  );

  //////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_reg      <= 1'b0;
      ph_wr_reg   <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else if (hready) begin
      ph_reg      <= hsel & htrans[1];
      ph_wr_reg   <= hwrite;
      ph_addr_reg <= haddr[7:0];
    end
  end

  // register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg   <= 32'h0000_0000;
      div_reg    <= DIV_RST;
      alarm_reg  <= 4'h0;
      acked_reg  <= 1'b0;
      health_reg <= 4'h0;
      mask_reg   <= '0;
    end else if (ph_reg && ph_wr_reg) begin
      case (ph_addr_reg)
        OFS_CTRL:   ctrl_reg   <= hwdata;
        OFS_DIV:    div_reg    <= hwdata;
        OFS_ALARM: begin
          alarm_reg <= hwdata[3:0];
          acked_reg <= hwdata[8];
        end
        OFS_HEALTH: health_reg <= hwdata[3:0];
        OFS_MASK:   mask_reg   <= hwdata[EV_W-1:0];
        default: ;  // unmapped writes are dropped
      endcase
    end
  end

  // read data, sampled off the captured offset
  always_comb begin
    hrdata = 32'h0000_0000;
    if (ph_reg && !ph_wr_reg) begin
      case (ph_addr_reg)
        OFS_CTRL:   hrdata = ctrl_reg;
        OFS_DIV:    hrdata = div_reg;
        OFS_ALARM:  hrdata = {23'h0, acked_reg, 4'h0, alarm_reg};
        OFS_HEALTH: hrdata = {28'h0, health_reg};
        OFS_STAT:   hrdata = {28'h0, stat_reg};
        OFS_MASK:   hrdata = {28'h0, mask_reg};
        OFS_DISP:   hrdata = {17'h0, chase_reg, phase_reg, seg_out};
        default:    hrdata = 32'h0000_0000;
      endcase
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_stat   = ph_reg && !ph_wr_reg && (ph_addr_reg == OFS_STAT);

  //////////////////////////////////////////////////////////////////////
  // phase sequencer; order chase, P, D, count; fault replaces chase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg  <= SDI_CHASE;
      pflash_reg <= 2'b00;
      tmr_reg    <= '0;
    end else begin
      tmr_reg <= tmr_reg + 40'h1;
      unique case (phase_reg)
        SDI_CHASE: begin
          if (ctrl_reg[CTRL_FAULT]) begin
            phase_reg <= SDI_FAULT;
          end else if (ctrl_reg[CTRL_SVC]) begin
            phase_reg <= SDI_SVC;
          end else if (ctrl_reg[CTRL_DONE]) begin
            phase_reg  <= SDI_PGLY;
            pflash_reg <= 2'b00;
          end
        end
        SDI_PGLY: begin
          // one on half then one off half, then on to D
          if (tick) begin
            pflash_reg <= pflash_reg + 2'b01;
            if (pflash_reg == 2'b01) begin
              phase_reg <= SDI_DGLY;
              tmr_reg   <= '0;
            end
          end
        end
        SDI_DGLY: begin
          if (ctrl_reg[CTRL_INIT] || (tmr_reg >= 40'(INIT_MAX))) begin
            phase_reg <= SDI_COUNT;
          end
        end
        SDI_COUNT: ;
        SDI_FAULT: ;                  // held for the operator
        SDI_SVC:   ;
        default: phase_reg <= SDI_CHASE;
      endcase
    end
  end

  // chase position and flash toggle on the divider tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chase_reg <= 4'h0;
      flash_reg <= 1'b0;
    end else if (tick) begin
      flash_reg <= ~flash_reg;
      chase_reg <= (chase_reg == 4'(CHASE_STEPS - 1)) ? 4'h0
                   : chase_reg + 4'h1;
    end
  end

  // segment pattern; the dot is always on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg_out <= 8'h80;
    end else begin
      unique case (phase_reg)
        SDI_CHASE: begin
          // a..f clockwise, then f..a back
          if (chase_reg < 4'h6) begin
            seg_out <= {1'b1, 7'(7'h01 << chase_reg)};
          end else begin
            seg_out <= {1'b1, 7'(7'h01 << (4'hb - chase_reg))};
          end
        end
        SDI_PGLY:  seg_out <= {1'b1, pflash_reg == 2'b00 ? GL_P : GL_BLANK};
        SDI_DGLY:  seg_out <= {1'b1, flash_reg ? GL_D : GL_BLANK};
        SDI_COUNT: seg_out <= {1'b1,
                     flash_reg ? sdi_digit(alarm_reg) : GL_BLANK};
        SDI_FAULT: seg_out <= {1'b1,
                     sdi_digit(ctrl_reg[CODE_LSB +: 4])};
        SDI_SVC: begin
          case (ctrl_reg[SVC_LSB +: 2])
            2'b00:   seg_out <= {1'b1, GL_C};
            2'b01:   seg_out <= {1'b1, GL_L};
            default: seg_out <= {1'b1, GL_U};
          endcase
        end
        default: seg_out <= 8'h80;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // processor lamp blinks while all alarms are acknowledged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp_cnt_reg <= 32'h0;
      proc_lamp    <= 1'b0;
    end else if (!acked_reg) begin
      lamp_cnt_reg <= 32'h0;
      proc_lamp    <= 1'b0;
    end else if (lamp_cnt_reg == 32'(LAMP_HALF - 1)) begin
      lamp_cnt_reg <= 32'h0;
      proc_lamp    <= ~proc_lamp;
    end else begin
      lamp_cnt_reg <= lamp_cnt_reg + 32'h1;
    end
  end

  // board and supply lamps follow the health bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_lamp   <= 1'b0;
      line_lamp   <= 1'b0;
      supply_lamp <= 2'b00;
    end else begin
      ctrl_lamp   <= health_reg[0];
      line_lamp   <= health_reg[1];
      supply_lamp <= health_reg[3:2];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // events; set wins over the read clear
  always_comb begin
    ev = '0;
    ev[EV_FAULT]   = (phase_reg == SDI_CHASE) &&
                     (ctrl_reg[CTRL_FAULT] || ctrl_reg[CTRL_SVC]);
    ev[EV_DONE]    = (phase_reg == SDI_CHASE) && ctrl_reg[CTRL_DONE];
    ev[EV_READY]   = (phase_reg == SDI_DGLY) && (ctrl_reg[CTRL_INIT] ||
                     (tmr_reg >= 40'(INIT_MAX)));
    ev[EV_TIMEOUT] = (phase_reg == SDI_CHASE) &&
                     (tmr_reg == 40'(DIAG_MAX));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (rd_stat ? '0 : stat_reg) | ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_reg & mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  AST_DOT: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 seg_out[7]) else $error("power dot dark");
  AST_ONEHOT: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_reg == SDI_CHASE) ##1 (phase_reg == SDI_CHASE) ##1
    (phase_reg == SDI_CHASE) |->
    $onehot(seg_out[6:0])) else $error("chase not one segment");
  AST_PORDER: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_reg == SDI_PGLY) ##1 (phase_reg != SDI_PGLY) |->
    phase_reg == SDI_DGLY) else $error("P not followed by D");
  AST_PONCE: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(phase_reg == SDI_PGLY) |=> seg_out[6:0] == GL_P)
    else $error("P glyph missing");
  AST_DEND: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_reg == SDI_DGLY && tmr_reg >= 40'(INIT_MAX)) |=>
    phase_reg == SDI_COUNT) else $error("D phase overran");
  AST_FAULT: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_reg == SDI_FAULT) |=> (phase_reg == SDI_FAULT) &&
    seg_out[6:0] == sdi_digit(ctrl_reg[CODE_LSB +: 4]))
    else $error("fault code not held");
  AST_LAMP: assert property (@(posedge hclk) disable iff (!hresetn)
    !acked_reg |=> !proc_lamp) else $error("lamp lit unacked");
  AST_TOUT: assert property (@(posedge hclk) disable iff (!hresetn)
    ev[EV_TIMEOUT] |=> stat_reg[EV_TIMEOUT])
    else $error("timeout not flagged");
  AST_HEALTH: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 ctrl_lamp == $past(health_reg[0]) &&
    line_lamp == $past(health_reg[1]))
    else $error("board lamp mismatch");
  AST_SUPPLY: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 supply_lamp == $past(health_reg[3:2]))
    else $error("supply lamp mismatch");
  AST_COUNT: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_reg == SDI_COUNT && flash_reg) |=>
    seg_out[6:0] == sdi_digit($past(alarm_reg)))
    else $error("alarm count wrong");
endmodule : sdi_indicator

// ==== test/sdi_panel.sv ====
// Purpose: front-panel observer standing in for the operator
// Assumes: one hclk, seg_out active high {dp,g,f,e,d,c,b,a}
// Notes:   flags a lost power dot, times the processor lamp
`timescale 1ns/10ps
module sdi_panel (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [7:0]  seg_out,
  input  wire logic        proc_lamp,
  output logic             dot_lost,
  output logic [15:0]      lamp_half
);
  logic [15:0] run_cnt;   // cycles since the lamp last changed
  logic        lamp_last; // lamp level one edge ago
  ////////////////////////////////////////////////////////////////////
  // an operator notices any moment without the power dot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dot_lost <= 1'b0;
    end else if (seg_out[7] !== 1'b1) begin
      dot_lost <= 1'b1;
    end
  end
  // time each lamp level; lamp_half keeps only the latest half
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_cnt   <= 16'h0001;
      lamp_last <= 1'b0;
      lamp_half <= 16'h0000;
    end else if (proc_lamp !== lamp_last) begin
      lamp_half <= run_cnt;
      run_cnt   <= 16'h0001;
      lamp_last <= proc_lamp;
    end else begin
      run_cnt <= run_cnt + 16'h0001;
    end
  end
endmodule : sdi_panel

// ==== test/sdi_indicator_test.sv ====
// Purpose: self-checking bench for the startup indicator
// Assumes: zero-wait slave, shortened lamp and limit counts
// Notes:   every expected value except the hresp zero goes through one queue
`timescale 1ns/10ps
module sdi_indicator_test;
  import sdi_pkg::*;
  localparam longint LH = 4; // lamp half period in cycles
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, obs;
  logic [1:0]  htrans;
  logic [7:0]  seg_out;
  logic [1:0]  supply_lamp;
  logic        proc_lamp, ctrl_lamp, line_lamp, irq;
  logic        rd_dp, obs_v, dot_lost;
  logic [15:0] lamp_half;
  logic [31:0] exp_q[$];   // expected results, oldest first
  int          err_total, check_count;
  logic [6:0]  dig[10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
                           7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  logic [3:0]  fc[6]   = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf};
  logic [6:0]  fg[6]   = '{7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h71};
  logic [6:0]  sg[3]   = '{7'h39, 7'h38, 7'h3e};
  logic [3:0]  h;
  int          idx[11] = '{0, 1, 2, 3, 4, 5, 4, 3, 2, 1, 0};
  ////////////////////////////////////////////////////////////////////
  sdi_indicator #(.LAMP_HALF(LH), .INIT_MAX(50), .DIAG_MAX(100)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .seg_out(seg_out), .proc_lamp(proc_lamp),
    .ctrl_lamp(ctrl_lamp), .line_lamp(line_lamp),
    .supply_lamp(supply_lamp), .irq(irq));
  sdi_panel panel (.hclk(hclk), .hresetn(hresetn), .seg_out(seg_out),
    .proc_lamp(proc_lamp), .dot_lost(dot_lost), .lamp_half(lamp_half));
  ////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  always #2 hclk = ~hclk;
  // one compare, counted
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  // watcher: read data in its data phase, panel samples when posted
  always @(posedge hclk) begin
    if (rd_dp) cmp(exp_q.pop_front(), hrdata);
    if (rd_dp) cmp(32'h0, {31'h0, hresp});
    if (obs_v) cmp(exp_q.pop_front(), obs);
  end
  // closing report, also reached by any expired wait
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // post one sampled output with its expected value
  task automatic note(input logic [31:0] e, input logic [31:0] v);
    @(negedge hclk);
    exp_q.push_back(e);
    obs   <= v;
    obs_v <= 1'b1;
    @(posedge hclk);
    obs_v <= 1'b0;
  endtask : note
  // wait for hready, bounded; a hang ends the run
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 16 && hready_ok() == 0; n++) @(posedge hclk);
    if (n == 16) begin
      err_total++;
      results();
    end
  endtask : wait_rdy
  function automatic bit hready_ok();
    return hreadyout === 1'b1;
  endfunction : hready_ok
  // single word transfer; d is write data or the expected read
  task automatic bus(input bit wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp  <= !wr;
    if (!wr) exp_q.push_back(d);
    @(posedge hclk);
    wait_rdy();
    rd_dp  <= 1'b0;
  endtask : bus
  // wait for a glyph on the digit, bounded, then compare it
  task automatic wait_seg(input logic [6:0] g, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge hclk);
      if (seg_out[6:0] === g) break;
    end
    if (n == lim) begin
      err_total++;
      results();
    end
    note({25'h0, g}, {25'h0, seg_out[6:0]});
  endtask : wait_seg
  task automatic rst();
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : rst
  ////////////////////////////////////////////////////////////////////
  // hang guard at 75000 cycles, well over the run length
  initial begin
    #300000;
    err_total++;
    results();
  end
  // main sequence
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0;
    hwrite = 0; hwdata = 0; rd_dp = 0; obs = 0; obs_v = 0;
    void'($urandom(32'h819d));
    repeat (2) @(posedge hclk);
    note(32'h100, {23'h0, seg_out, irq});
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, OFS_DIV, DIV_RST);
    bus(1, 8'h1c, 32'hffffffff);
    bus(0, 8'h1c, 32'h0);
    bus(0, OFS_MASK, 32'h0);
    $display("test reset and map done");
    // lamps follow random health words
    repeat (4) begin
      h = 4'($urandom % 16);
      bus(1, OFS_HEALTH, {28'h0, h});
      bus(0, OFS_HEALTH, {28'h0, h});
      note({28'h0, h}, {28'h0, supply_lamp, line_lamp, ctrl_lamp});
    end
    $display("test health lamps done");
    // long chase: timeout stays masked, then unmasked and cleared
    repeat (120) @(posedge hclk);
    note(32'h0, {31'h0, irq});
    bus(1, OFS_MASK, 32'h8);
    bus(0, OFS_MASK, 32'h8);
    note(32'h1, {31'h0, irq});
    bus(0, OFS_STAT, 32'h8);
    bus(0, OFS_STAT, 32'h0);
    note(32'h0, {31'h0, irq});
    $display("test timeout irq done");
    // segment chase order at a fast step
    rst();
    bus(1, OFS_DIV, 32'h8);
    for (int i = 0; i < 11; i++) wait_seg(7'h01 << idx[i], 120);
    $display("test chase done");
    // every fault code replaces the chase and stays
    for (int i = 0; i < 6; i++) begin
      rst();
      bus(1, OFS_MASK, 32'h1);
      bus(1, OFS_CTRL, {24'h0, fc[i], 4'h2});
      wait_seg(fg[i], 20);
      note(32'h1, {31'h0, irq});
      bus(0, OFS_STAT, 32'h1);
      repeat (30) @(posedge hclk);
      wait_seg(fg[i], 1);
    end
    $display("test fault codes done");
    // service glyphs
    for (int s = 0; s < 3; s++) begin
      rst();
      bus(1, OFS_CTRL, 32'h8 | (s << 8));
      wait_seg(sg[s], 20);
      bus(0, OFS_DISP, {17'h0, 4'h1, 3'b101, 1'b1, sg[s]});
    end
    $display("test service glyphs done");
    // full startup: P, D, then the alarm count and the lamp
    rst();
    h = 4'($urandom % 10);
    bus(1, OFS_DIV, 32'h2);
    bus(1, OFS_ALARM, {23'h0, 1'b1, 4'h0, h});
    bus(1, OFS_CTRL, 32'h1);
    wait_seg(GL_P, 20);
    wait_seg(GL_D, 20);
    bus(1, OFS_CTRL, 32'h5);
    wait_seg(dig[h], 60);
    repeat (20) @(posedge hclk);
    note(32'(LH), {16'h0, lamp_half});
    note(32'h0, {31'h0, dot_lost});
    $display("test startup sequence done");
    results();
  end
endmodule : sdi_indicator_test
